//--- src/sfc_top.v
/*
 * Command and operation logic of a synchronous flash device:
 * command decode, mode register, row/column latch, burst read with
 * latency and output mask, program and erase sequences with polling,
 * and pin continuity test mode.
 * Assumes inputs synchronous to clock; data bus as in/out/enable.
 */
`timescale 1ns/10ps
`include "sfc_consts.vh"

// How it works
// RULE_01: all strobes high means no operation
// RULE_02: chip select high ignores all inputs; clock enable, output mask, width pin and continuity logic still act
// RULE_03: controller never loads mode mid operation; the bench issues one while busy and the design ignores it
// RULE_04: all strobes low loads address bits 7..0
// RULE_05: controller waits three cycles after mode load
// RULE_06: mode fields: length, type, latencies, identity read
// RULE_07: reset mode: array, ras two, cas five, length four
// RULE_08: width pin high selects thirty-two bit words
// RULE_09: ras low latches row, cas low column
// RULE_10: ras latency one or two, cas two..six
// RULE_11: mask sampled high blanks data two cycles later
// RULE_12: burst read starts data after cas latency
// RULE_13: burst end floats bus; new read restarts
// RULE_14: eight sectors, erased cells read ones
// RULE_15: six cycle erase sequence with 30h ends
// RULE_16: commands ignored while program or erase busy; the design still takes reads and row/column latches
// RULE_17: four cycle program sequence starts next edge
// RULE_18: program only clears bits, erase sets them
// RULE_19: program poll returns inverted bit seven
// RULE_20: erase poll returns zero on bit seven
// RULE_21: continuity entry, mask wait, then pins follow
// RULE_22: exit continuity on address key, wait recovery
// RULE_23: only low data byte forms command value
// RULE_24: clock enable low freezes all state; the program/erase counter and continuity logic keep running
// RULE_25: controller idles one cycle after power down
// RULE_26: broken sequence returns recogniser to idle
// RULE_27: busy flag set by program, erase operations
module sfc_top #(
	parameter AW        = 8,
	parameter PROG_CYC  = `SFC_PROG_CYC,
	parameter ERASE_CYC = `SFC_ERASE_CYC,
	parameter CONT_CYC  = `SFC_CONT_CYC
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	// Command pins
	input  wire        cke,
	input  wire        cs_n,
	input  wire        ras_n,
	input  wire        cas_n,
	input  wire        mode_register_strobe_n,
	input  wire        we_n,
	input  wire        output_mask,
	input  wire        width_select_pin,
	input  wire [12:0] addr,
	// Data bus
	input  wire [31:0] dq_in,
	output reg  [31:0] dq_out,
	output reg  [31:0] dq_oe,
	// Status
	output reg         busy_r,
	output reg  [7:0]  mode_r
);
	localparam ST_IDLE = 3'h0;
	localparam ST_K1   = 3'h1;
	localparam ST_K2   = 3'h2;
	localparam ST_PROG = 3'h3;
	localparam ST_E3   = 3'h4;
	localparam ST_E4   = 3'h5;
	localparam ST_E5   = 3'h6;
	localparam ST_CONT = 3'h7;

	/****************************************************************/
	/* Command decode                                               */
	/****************************************************************/
	wire        live   = cke & ~cs_n; // RULE_02 RULE_24
	wire        c_mrs  = live & ~ras_n & ~cas_n
			& ~mode_register_strobe_n; // RULE_04
	wire        c_act  = live & ~ras_n & cas_n
			& mode_register_strobe_n; // RULE_09
	wire        c_cas  = live & ras_n & ~cas_n
			& mode_register_strobe_n; // RULE_12
	wire        c_wr   = c_cas & ~we_n;
	wire        c_rd   = c_cas & we_n;
	wire [7:0]  cmd    = dq_in[7:0]; // RULE_23
	reg         cke_d_r;
	reg  [1:0]  mrs_wait_r;
	reg  [12:0] row_r;
	reg  [7:0]  col_r;
	reg  [2:0]  seq_r;
	reg  [12:0] seq_row_r;
	reg         cont_r;
	reg  [15:0] cont_cnt_r;
	reg         cont_arm_r;

	function [2:0] cas_lat;
		input [7:0] m;
		begin
			cas_lat = m[`SFC_MODE_CL_HI:`SFC_MODE_CL_LO];
			if (cas_lat < 3'd2 || cas_lat > 3'd6)
				cas_lat = 3'd5; // RULE_10
		end
	endfunction

	// Sector index sits in the top bits of the array address.
	function [AW-1:0] map_addr;
		input [12:0] r;
		input [2:0]  c;
		begin
			map_addr = {r[12:10], r[AW-7:0], c};
		end
	endfunction

	function key_hit;
		input [12:0] r;
		input [7:0]  c;
		input [7:0]  d;
		input [12:0] kr;
		input [7:0]  kc;
		input [7:0]  kd;
		begin
			key_hit = (r == kr) && (c == kc) && (d == kd);
		end
	endfunction

	/****************************************************************/
	/* Program and erase engine                                     */
	/****************************************************************/
	reg  [15:0] op_cnt_r;
	reg         op_erase_r;
	reg  [AW-1:0] op_addr_r;
	reg  [31:0] op_data_r;
	reg         start_prog_r;
	reg         start_erase_r;
	reg  [2:0]  sect_r;
	wire [AW-1:0] rd_addr;
	wire [31:0] mem_q;
	wire [2:0]  sector_index = seq_row_r[12:10]; // RULE_14
	wire        seq_cyc = c_wr & ~busy_r & ~cont_r; // RULE_16

	always @(posedge clock) begin
		if (rst) begin
			cke_d_r       <= 1'b1;
			mode_r        <= `SFC_MODE_DEFAULT; // RULE_07
			mrs_wait_r    <= 2'h0;
			row_r         <= 13'h0000;
			col_r         <= 8'h00;
			seq_r         <= ST_IDLE;
			seq_row_r     <= 13'h0000;
			busy_r        <= 1'b0;
			op_cnt_r      <= 16'h0000;
			op_erase_r    <= 1'b0;
			op_addr_r     <= {AW{1'b0}};
			op_data_r     <= 32'h00000000;
			start_prog_r  <= 1'b0;
			start_erase_r <= 1'b0;
			sect_r        <= 3'h0;
			cont_r        <= 1'b0;
			cont_cnt_r    <= 16'h0000;
			cont_arm_r    <= 1'b0;
		end else begin
			cke_d_r       <= cke;
			start_prog_r  <= 1'b0;
			start_erase_r <= 1'b0;
			if (mrs_wait_r != 2'h0 && cke)
				mrs_wait_r <= mrs_wait_r - 2'h1;
			if (c_mrs && cke_d_r && !busy_r) begin
				mode_r     <= addr[7:0]; // RULE_04 RULE_06
				mrs_wait_r <= 2'd`SFC_MRS_BUSY_CYC; // RULE_05
			end
			if (c_act)
				row_r <= addr; // RULE_09
			if (c_cas)
				col_r <= addr[7:0]; // RULE_09
			if (seq_cyc) begin
				case (seq_r)
				ST_IDLE: begin
					seq_r <= key_hit(row_r, addr[7:0], cmd,
						`SFC_KEY_RA1, `SFC_KEY_CA1, `SFC_DAT_AA)
						? ST_K1 : ST_IDLE;
				end
				ST_K1: begin
					seq_r <= key_hit(row_r, addr[7:0], cmd,
						`SFC_KEY_RA2, `SFC_KEY_CA2, `SFC_DAT_55)
						? ST_K2 : ST_IDLE; // RULE_26
				end
				ST_K2: begin
					if (key_hit(row_r, addr[7:0], cmd, `SFC_KEY_RA1,
							`SFC_KEY_CA1, `SFC_DAT_PROG))
						seq_r <= ST_PROG;
					else if (key_hit(row_r, addr[7:0], cmd,
							`SFC_KEY_RA1, `SFC_KEY_CA1,
							`SFC_DAT_ERASE1))
						seq_r <= ST_E3;
					else
						seq_r <= ST_IDLE; // RULE_26
				end
				ST_PROG: begin
					op_addr_r    <= map_addr(row_r, addr[2:0]);
					op_data_r    <= width_select_pin ? dq_in
						: {16'hffff, dq_in[15:0]}; // RULE_08
					start_prog_r <= 1'b1; // RULE_17
					seq_r        <= ST_IDLE;
				end
				ST_E3: begin
					seq_r <= key_hit(row_r, addr[7:0], cmd,
						`SFC_KEY_RA1, `SFC_KEY_CA1, `SFC_DAT_AA)
						? ST_E4 : ST_IDLE; // RULE_26
				end
				ST_E4: begin
					seq_r <= key_hit(row_r, addr[7:0], cmd,
						`SFC_KEY_RA2, `SFC_KEY_CA2, `SFC_DAT_55)
						? ST_E5 : ST_IDLE; // RULE_26
				end
				ST_E5: begin
					seq_row_r <= row_r;
					if (cmd == `SFC_DAT_ERASE) begin
						start_erase_r <= 1'b1; // RULE_15
						sect_r        <= row_r[12:10];
					end else if (key_hit(row_r, addr[7:0], cmd,
							`SFC_KEY_RA1, `SFC_KEY_CA1,
							`SFC_DAT_CONT)) begin
						cont_r     <= 1'b1; // RULE_21
						cont_arm_r <= 1'b0;
						cont_cnt_r <= 16'h0000;
					end
					seq_r <= ST_IDLE;
				end
				default: seq_r <= ST_IDLE;
				endcase
			end
			if (start_prog_r || start_erase_r) begin
				busy_r     <= 1'b1; // RULE_27
				op_erase_r <= start_erase_r;
				op_cnt_r   <= start_erase_r ? ERASE_CYC[15:0]
					: PROG_CYC[15:0];
			end else if (busy_r) begin
				if (op_cnt_r == 16'h0001)
					busy_r <= 1'b0; // RULE_27
				op_cnt_r <= op_cnt_r - 16'h0001;
			end
			if (cont_r) begin
				if (output_mask && cont_cnt_r != CONT_CYC[15:0])
					cont_cnt_r <= cont_cnt_r + 16'h0001;
				if (!output_mask && cont_cnt_r == CONT_CYC[15:0])
					cont_arm_r <= 1'b1; // RULE_21
				if (addr[0] && addr[2] && addr[11] && !addr[1]
						&& !addr[10] && !addr[12] && cont_arm_r)
					cont_r <= 1'b0; // RULE_22
			end
		end
	end

	sfc_mem #(
		.AW(AW),
		.DW(32),
		.SW(3)
	) u_mem (
		.clock  (clock),
		.addr   (rd_addr),
		.prog   (start_prog_r),
		.wdata  (op_data_r),
		.erase  (start_erase_r),
		.sector (sect_r),
		.rdata  (mem_q)
	);

	/****************************************************************/
	/* Burst read pipeline                                          */
	/****************************************************************/
	reg  [7:0]  lat_r;
	reg  [3:0]  beat_r;
	reg  [2:0]  bofs_r;
	reg  [2:0]  bcnt_r;
	reg  [7:0]  bcol_r;
	reg         bact_r;
	reg  [2:0]  mask_r;
	reg         blast_r;
	reg  [AW-1:0] rd_addr_d_r;
	wire [2:0]  blen = mode_r[`SFC_MODE_BL_LO] ? 3'd7 : 3'd3;
	wire [2:0]  bseq = mode_r[`SFC_MODE_BT_BIT]
			? (bcol_r[2:0] ^ bcnt_r)
			: (bcol_r[2:0] + bcnt_r);
	wire [2:0]  bidx = (bseq & blen) | (bcol_r[2:0] & ~blen);
	wire        beat = bact_r;

	assign rd_addr = start_prog_r ? op_addr_r
			: map_addr(row_r, bidx);

	// Address of the word now on the array read data.
	always @(posedge clock) begin
		if (rst)
			rd_addr_d_r <= {AW{1'b0}};
		else
			rd_addr_d_r <= rd_addr;
	end

	always @(posedge clock) begin
		if (rst) begin
			lat_r  <= 8'h00;
			bact_r <= 1'b0;
			blast_r <= 1'b0;
			bcnt_r <= 3'h0;
			bcol_r <= 8'h00;
			mask_r <= 3'h0;
			dq_out <= 32'h00000000;
			dq_oe  <= 32'h00000000;
		end else if (cont_r) begin
			dq_oe  <= cont_arm_r ? 32'hffffffff : 32'h00000000;
			dq_out <= {ras_n, 11'h000, cke, 4'h0, mode_register_strobe_n,
				addr[12], ras_n, addr[7:0], cas_n, cs_n, addr[12],
				mode_register_strobe_n}; // RULE_21
		end else if (cke) begin
			mask_r <= {mask_r[1:0], output_mask}; // RULE_11
			lat_r  <= {lat_r[6:0], 1'b0};
			if (c_rd && !cont_r) begin
				lat_r[0] <= 1'b1; // RULE_12 RULE_13
				bcnt_r   <= 3'h0;
				bcol_r   <= addr[7:0];
			end
			if (lat_r[cas_lat(mode_r) - 3'd2] || bact_r) begin
				if (lat_r[cas_lat(mode_r) - 3'd2]) begin
					bact_r  <= 1'b1;
					bcnt_r  <= 3'h1;
					blast_r <= 1'b0;
				end else if (blast_r) begin
					bact_r  <= 1'b0; // RULE_13
					blast_r <= 1'b0;
				end else if (bcnt_r == blen) begin
					blast_r <= 1'b1;
				end else begin
					bcnt_r <= bcnt_r + 3'h1;
				end
			end
			dq_oe  <= (beat && !mask_r[1]) ? (width_select_pin
				? 32'hffffffff : 32'h0000ffff) : 32'h00000000;
			if (busy_r && op_erase_r)
				dq_out <= {24'h000000, 1'b0, 7'h00}; // RULE_20
			else if (busy_r && rd_addr_d_r == op_addr_r)
				dq_out <= {24'h000000, ~op_data_r[7], 7'h00}; // RULE_19
			else if (width_select_pin || !bcol_r[0])
				dq_out <= mem_q; // RULE_08
			else
				dq_out <= {16'h0000, mem_q[31:16]};
		end
	end
endmodule

//--- src/sfc_consts.vh
/*
 * Constants for the synchronous flash command block: mode register
 * fields and defaults, command codes, address keys and timing counts.
 * Assumes a 250 MHz core clock.
 */
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

/****************************************************************/
/* Mode register                                                */
/****************************************************************/
`define SFC_MODE_DEFAULT   8'h6a
`define SFC_MODE_BL_LO     0
`define SFC_MODE_BL_HI     1
`define SFC_MODE_BT_BIT    2
`define SFC_MODE_CL_LO     3
`define SFC_MODE_CL_HI     5
`define SFC_MODE_RL_BIT    6
`define SFC_MODE_ID_BIT    7
`define SFC_MRS_BUSY_CYC   3

/****************************************************************/
/* Command keys                                                 */
/****************************************************************/
`define SFC_KEY_RA1        13'h00aa
`define SFC_KEY_CA1        8'h55
`define SFC_KEY_RA2        13'h0055
`define SFC_KEY_CA2        8'h2a
`define SFC_DAT_AA         8'haa
`define SFC_DAT_55         8'h55
`define SFC_DAT_PROG       8'ha0
`define SFC_DAT_ERASE1     8'h80
`define SFC_DAT_ERASE      8'h30
`define SFC_DAT_CONT       8'h70

/****************************************************************/
/* Timing                                                       */
/****************************************************************/
`define SFC_CLK_MHZ        250
`define SFC_CONT_US        5
`define SFC_CONT_CYC       (`SFC_CONT_US * `SFC_CLK_MHZ)
`define SFC_PROG_CYC       64
`define SFC_ERASE_CYC      256

`endif

//--- src/sfc_mem.v
/*
 * Flash cell array model with one-cycle registered read.
 * Write ANDs data in (program), erase sets a sector to all ones.
 * Assumes a single synchronous clock.
 */
`timescale 1ns/10ps
module sfc_mem #(
	parameter AW = 8,
	parameter DW = 32,
	parameter SW = 3
) (
	// Clock only, no reset
	input  wire          clock,
	// Access
	input  wire [AW-1:0] addr,
	input  wire          prog,
	input  wire [DW-1:0] wdata,
	input  wire          erase,
	input  wire [SW-1:0] sector,
	output reg  [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	integer i;

	always @(posedge clock) begin
		rdata <= mem[addr];
		if (erase) begin
			for (i = 0; i < (1<<AW); i = i + 1) begin
				if (i[AW-1:AW-SW] == sector)
					mem[i] <= {DW{1'b1}}; // RULE_14
			end
		end else if (prog) begin
			mem[addr] <= mem[addr] & wdata; // RULE_18
		end
	end
endmodule

//--- tb/sfc_chk.sv
/*
 * Port checker for sfc_top, bound to the design top.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module sfc_chk #(
	parameter ERASE_CYC = 256
) (
	// Clock and reset
	input wire        clock,
	input wire        rst,
	// Command pins
	input wire        cke,
	input wire        cs_n,
	input wire        ras_n,
	input wire        cas_n,
	input wire        mode_register_strobe_n,
	input wire        we_n,
	input wire        output_mask,
	input wire        width_select_pin,
	input wire [12:0] addr,
	// Data and status
	input wire [31:0] dq_in,
	input wire [31:0] dq_out,
	input wire [31:0] dq_oe,
	input wire        busy_r,
	input wire [7:0]  mode_r
);
	reg [15:0] bcnt_r;

	always @(posedge clock)
		bcnt_r <= (rst || !busy_r) ? 16'h0 : bcnt_r + 16'h1;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	reset_vals_a:
	assert property (disable iff (1'b0) rst |=> mode_r == 8'h6a
		&& !busy_r && dq_oe == 32'h0) else $error("reset values wrong");
	mode_load_a:
	assert property ($past(cke) && cke && !cs_n && !ras_n && !cas_n
		&& !mode_register_strobe_n && !busy_r
		|=> mode_r == $past(addr[7:0])) else $error("mode load wrong");
	deselect_a:
	assert property (cs_n |=> $stable(mode_r))
		else $error("deselect changed mode");
	nop_hold_a:
	assert property (!cs_n && ras_n && cas_n && mode_register_strobe_n
		|=> $stable(mode_r)) else $error("nop changed mode");
	mask_blank_a:
	assert property (output_mask |-> ##[2:3] dq_oe == 32'h0)
		else $error("mask did not blank");
	busy_mode_a:
	assert property (busy_r |=> $stable(mode_r))
		else $error("mode changed while busy");
	busy_len_a:
	assert property (bcnt_r <= ERASE_CYC + 4) else $error("busy too long");
	suspend_a:
	assert property (!cke ##1 !cke |=> $stable(dq_oe) && $stable(dq_out))
		else $error("suspend did not freeze");

	cover property ($rose(busy_r));
	cover property (output_mask);
	cover property (!cke ##1 !cke);
endmodule

bind sfc_top sfc_chk #(.ERASE_CYC(ERASE_CYC)) u_chk (.clock(clock),
	.rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
	.mode_register_strobe_n(mode_register_strobe_n), .we_n(we_n),
	.output_mask(output_mask), .width_select_pin(width_select_pin),
	.addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
	.busy_r(busy_r), .mode_r(mode_r));

//--- tb/sfc_ctl.sv
/*
 * Controller model: drives command pins and write data.
 * Assumes its tasks are called from one bench process.
 */
`timescale 1ns/10ps
module sfc_ctl (
	// Clock
	input  wire        clock,
	// Command pins
	output reg         cs_n,
	output reg         ras_n,
	output reg         cas_n,
	output reg         mode_register_strobe_n,
	output reg         we_n,
	output reg  [12:0] addr,
	output reg  [31:0] dq_in
);
	initial begin
		{cs_n, ras_n, cas_n, mode_register_strobe_n, we_n} = 5'h0f;
		addr = 13'h0;
		dq_in = 32'h0;
	end

	// Command bits are chip select, row, column, strobe, write.
	task cmd(input [4:0] c, input [12:0] a, input [31:0] d);
		begin
			@(posedge clock);
			{cs_n, ras_n, cas_n, mode_register_strobe_n, we_n} <= c;
			addr <= a;
			dq_in <= d;
		end
	endtask
	// Idle cycles toggle the released lines so no stale value lingers.
	task nop(input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1)
				cmd(5'h0f, ~addr, ~dq_in);
		end
	endtask
	task pair(input [12:0] r, input [7:0] c, input [7:0] k);
		begin
			cmd(5'h07, r, ~dq_in);
			cmd(5'h0a, {5'h0, c}, {24'ha5c3e1, k});
		end
	endtask
	task keys(input [7:0] k);
		begin
			pair(13'h00aa, 8'h55, 8'haa);
			pair(13'h0055, 8'h2a, 8'h55);
			pair(13'h00aa, 8'h55, k);
		end
	endtask
	task prog(input [12:0] r, input [7:0] c, input [31:0] d);
		begin
			keys(8'ha0);
			cmd(5'h07, r, ~dq_in);
			cmd(5'h0a, {5'h0, c}, d);
			nop(1);
		end
	endtask
	task erase(input [12:0] r);
		begin
			keys(8'h80);
			pair(13'h00aa, 8'h55, 8'haa);
			pair(13'h0055, 8'h2a, 8'h55);
			pair(r, 8'h00, 8'h30);
			nop(1);
		end
	endtask
	task mode(input [7:0] m);
		begin
			cmd(5'h01, {5'h0, m}, ~dq_in);
			nop(3);
		end
	endtask
	task rd(input [12:0] r, input [7:0] c);
		begin
			cmd(5'h07, r, ~dq_in);
			nop(1);
			cmd(5'h0b, {5'h0, c}, ~dq_in);
			nop(1);
		end
	endtask
endmodule

//--- tb/testbench.sv
/*
 * Self-checking bench for sfc_top driven by the controller model.
 * Assumes shortened program and erase counts set at the instance.
 */
`timescale 1ns/10ps
module testbench;
	reg         clock;
	reg         rst;
	reg         cke;
	reg         output_mask;
	reg         width_select_pin;
	wire        cs_n, ras_n, cas_n, strobe_n, we_n;
	wire [12:0] addr;
	wire [31:0] dq_in, dq_out, dq_oe;
	wire        busy_r;
	wire [7:0]  mode_r;
	integer     num_errors, cmp_count, seed, lat, lat5, beats, j;
	reg  [31:0] first, d, exp;

	always #2 clock = ~clock;

	sfc_ctl ctl (.clock(clock), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.mode_register_strobe_n(strobe_n), .we_n(we_n), .addr(addr),
		.dq_in(dq_in));
	sfc_top #(.PROG_CYC(40), .ERASE_CYC(60), .CONT_CYC(4)) dut (
		.clock(clock), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .mode_register_strobe_n(strobe_n), .we_n(we_n),
		.output_mask(output_mask), .width_select_pin(width_select_pin),
		.addr(addr),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .busy_r(busy_r),
		.mode_r(mode_r));

	task close_out;
		begin
			$display("errors %0d compares %0d", num_errors, cmp_count);
			if (num_errors == 0 && cmp_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wbusy(input v);
		integer i;
		begin
			for (i = 0; i < 400 && busy_r !== v; i = i + 1) begin
				@(posedge clock);
				#1;
			end
			chk("busy", {31'h0, v}, {31'h0, busy_r});
			if (busy_r !== v)
				close_out;
		end
	endtask
	// Reads the test word; 1 pulses the mask, 2 suspends the clock.
	task rdc(input integer md);
		begin
			ctl.rd(13'h0400, 8'h04);
			lat = 0;
			beats = 0;
			first = 32'h0;
			for (j = 1; j < 24; j = j + 1) begin
				@(posedge clock);
				output_mask <= (md == 1 && j == lat5 - 1);
				cke <= !(md == 2 && j >= lat5 && j < lat5 + 3);
				#1;
				if (dq_oe[0] === 1'b1) begin
					if (beats == 0) begin
						lat = j;
						first = dq_out;
					end
					beats = beats + 1;
				end
			end
		end
	endtask

	initial begin
		clock = 0;
		rst = 1;
		cke = 1;
		output_mask = 0;
		width_select_pin = 1;
		num_errors = 0;
		cmp_count = 0;
		seed = 32'h007b;
		lat5 = 0;
		repeat (20) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		#1;
		chk("mode", 32'h6a, {24'h0, mode_r});
		chk("oe", 32'h0, dq_oe);
		d = $random(seed);
		ctl.cmd(5'h10, d[12:0], d);
		ctl.nop(2);
		chk("desel", 32'h6a, {24'h0, mode_r});
		repeat (4) begin
			d = $random(seed);
			ctl.mode(d[7:0]);
			chk("mode", {24'h0, d[7:0]}, {24'h0, mode_r});
		end
		ctl.mode(8'h6a);
		exp = 32'hffffffff;
		ctl.erase(13'h0400);
		wbusy(1);
		ctl.mode(8'h12);
		chk("mode", 32'h6a, {24'h0, mode_r});
		rdc(0);
		chk("poll7", 32'h0, {31'h0, first[7]});
		lat5 = lat;
		wbusy(0);
		rdc(0);
		chk("erased", exp, first);
		chk("beats", 32'h4, beats);
		repeat (2) begin
			d = $random(seed);
			exp = exp & d;
			ctl.prog(13'h0400, 8'h04, d);
			wbusy(1);
			rdc(0);
			chk("poll7", {31'h0, ~d[7]}, {31'h0, first[7]});
			wbusy(0);
			rdc(0);
			chk("data", exp, first);
		end
		ctl.mode(8'h12);
		rdc(0);
		chk("lat", lat5 - 3, lat);
		ctl.mode(8'h6a);
		rdc(1);
		chk("beats", 32'h3, beats);
		rdc(2);
		chk("suspend", 32'h7, beats);
		@(posedge clock);
		width_select_pin <= 1'b0;
		rdc(0);
		chk("x16", {16'h0, exp[15:0]}, {16'h0, first[15:0]});
		chk("x16oe", 32'h0, {16'h0, dq_oe[31:16]});
		close_out;
	end
endmodule
